// ### hw/noise_reducer.sv
// Motion-adaptive recursive temporal noise reducer for luma and two chroma channels
`timescale 1ns/10ps
// Functional notes
// - Active-low asynchronous reset restores control defaults, zeroes pixel data and empties the write queue.
// - Pixel and register state changes only on clock edges where the pixel enable is high.
// - The 3-bit control address picks the write target and readback source.
// - A write needs chip select and write strobe both low.
// - An 8-bit readback bus shows the register chosen by the address.
// - Active video marks the visible line; used only for the split boundary.
// - Filtered outputs have input widths and are valid on enabled edges.
// - Write data to the delay memory matches the input widths.
// - Recursive filter per channel; luma frame difference weakens it on motion.
// - Motion adaptation can be turned off for stronger fixed filtering.
// - Registers are reached through an 8-bit processor-style data path.
// - Output equals delayed plus k times the live minus delayed difference.
// - Absolute luma difference is clipped at 127 before the k lookup.
// - Data is captured on the strobe rising edge while chip select is low.
module noise_reducer #(
  parameter int YW = 10,
  parameter int CW = 10
) (
  input wire logic clk_sys,
  input wire logic sys_rst_n,
  input wire logic pixEn,
  input wire logic [2:0] ctrlAddr,
  input wire logic [7:0] ctrlData,
  input wire logic ctrl_select_n,
  input wire logic ctrl_write_strobe_n,
  input wire logic activeVideo,
  input wire logic [YW-1:0] lumaLiveIn,
  input wire logic [CW-1:0] blue_diff_live_in,
  input wire logic [CW-1:0] red_diff_live_in,
  input wire logic [YW-1:0] luma_delayed_in,
  input wire logic [CW-1:0] blue_diff_delayed_in,
  input wire logic [CW-1:0] red_diff_delayed_in,
  output logic [7:0] ctrl_readback,
  output logic ctrlBusy,
  output logic [YW-1:0] luma_filtered_out,
  output logic [CW-1:0] blue_diff_filtered_out,
  output logic [CW-1:0] red_diff_filtered_out,
  output logic [YW-1:0] lumaToDelayMem,
  output logic [CW-1:0] blue_diff_to_delay_mem,
  output logic [CW-1:0] red_diff_to_delay_mem
);
  localparam int MW = (YW > CW) ? YW : CW;
  localparam logic signed [MW+5:0] ROUND = (MW+6)'(nr_pkg::K_ROUND);
  localparam logic [MW-1:0] YMAX = MW'({YW{1'b1}});
  localparam logic [MW-1:0] CMAX = MW'({CW{1'b1}});

  function automatic logic [MW-1:0] blend(input logic [MW-1:0] live, input logic [MW-1:0] dly,
                                          input logic [3:0] k, input logic [MW-1:0] maxv);
    logic signed [MW+5:0] d;
    logic signed [MW+5:0] p;
    logic signed [MW+5:0] s;
    d = $signed({6'h00, live}) - $signed({6'h00, dly});
    p = d * $signed({{(MW+2){1'b0}}, k});
    s = $signed({6'h00, dly}) + ((p + ROUND) >>> nr_pkg::K_SHIFT);
    if (s < 0)
      blend = '0;
    else if (s > $signed({6'h00, maxv}))
      blend = maxv;
    else
      blend = s[MW-1:0];
  endfunction

  // Control pins come from an unclocked processor port
  logic [12:0] pinSync1_reg;
  logic [12:0] pinSync2_reg;
  logic wrPrev_reg;
  logic [2:0] addrSync;
  logic wrEvent;
  logic fifoInReady;
  logic fifoOutValid;
  nr_pkg::regWrite_s wrReq;
  nr_pkg::regWrite_s wrPop;
  logic commit;
  logic ctrlBusy_reg;

  always_ff @(posedge clk_sys or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      pinSync1_reg <= 13'h1800;
      pinSync2_reg <= 13'h1800;
      wrPrev_reg <= 1'b1;
      ctrlBusy_reg <= 1'b0;
    end
    else
    begin
      pinSync1_reg <= {ctrl_select_n, ctrl_write_strobe_n, ctrlAddr, ctrlData};
      pinSync2_reg <= pinSync1_reg;
      wrPrev_reg <= pinSync2_reg[11];
      ctrlBusy_reg <= !fifoInReady;
    end
  end

  // Address and data are delayed with the strobe, so they are the values at its rise
  assign addrSync = pinSync2_reg[10:8];
  assign wrEvent = pinSync2_reg[11] && !wrPrev_reg && !pinSync2_reg[12];
  assign wrReq = '{addr: addrSync, data: pinSync2_reg[7:0]};
  // Writes queue until an enabled edge so up to 16 are kept while the enable is low
  assign commit = fifoOutValid && pixEn;

  nr_fifo #(
    .WIDTH($bits(nr_pkg::regWrite_s)),
    .DEPTH(nr_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys(clk_sys),
    .sys_rst_n(sys_rst_n),
    .inValid(wrEvent),
    .inReady(fifoInReady),
    .inData(wrReq),
    .outValid(fifoOutValid),
    .outReady(pixEn),
    .outData(wrPop)
  );

  logic [7:0] ctrlRegs_reg [0:nr_pkg::NUM_RW_REGS-1];

  always_ff @(posedge clk_sys or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      for (int i = 0; i < nr_pkg::NUM_RW_REGS; i++)
        ctrlRegs_reg[i] <= nr_pkg::RST_VALS[i*8 +: 8];
    end
    else if (commit && (wrPop.addr < 3'(nr_pkg::NUM_RW_REGS)))
    begin
      ctrlRegs_reg[wrPop.addr] <= wrPop.data;
    end
  end

  wire [7:0] ctrl1 = ctrlRegs_reg[nr_pkg::REG_CTRL1];
  wire [7:0] modeReg = ctrlRegs_reg[nr_pkg::REG_MODE];
  wire [15:0] splitPos = {ctrlRegs_reg[nr_pkg::REG_SPLIT_HI], ctrlRegs_reg[nr_pkg::REG_SPLIT_LO]};

  // Stage 1: capture live and delayed samples
  logic [YW-1:0] y1_reg;
  logic [YW-1:0] yd1_reg;
  logic [CW-1:0] cb1_reg;
  logic [CW-1:0] cbd1_reg;
  logic [CW-1:0] cr1_reg;
  logic [CW-1:0] crd1_reg;
  logic av1_reg;
  logic [15:0] hCount_reg;

  always_ff @(posedge clk_sys or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      y1_reg <= '0;
      yd1_reg <= '0;
      cb1_reg <= '0;
      cbd1_reg <= '0;
      cr1_reg <= '0;
      crd1_reg <= '0;
      av1_reg <= 1'b0;
      hCount_reg <= '0;
    end
    else if (pixEn)
    begin
      y1_reg <= lumaLiveIn;
      yd1_reg <= luma_delayed_in;
      cb1_reg <= blue_diff_live_in;
      cbd1_reg <= blue_diff_delayed_in;
      cr1_reg <= red_diff_live_in;
      crd1_reg <= red_diff_delayed_in;
      av1_reg <= activeVideo;
      hCount_reg <= av1_reg ? hCount_reg + 16'h0001 : 16'h0000;
    end
  end

  // Motion from the clipped luma frame difference
  wire [YW-1:0] yAbs = (y1_reg >= yd1_reg) ? y1_reg - yd1_reg : yd1_reg - y1_reg;
  wire [6:0] motionNow = (yAbs > YW'(nr_pkg::MOTION_CLIP)) ? nr_pkg::MOTION_CLIP
                                                           : yAbs[6:0];
  wire [6:0] thr = nr_pkg::speedThr(ctrl1[nr_pkg::SPEED_LSB +: 3]);
  wire bypass = modeReg[nr_pkg::MODE_SPLIT] && av1_reg && (hCount_reg < splitPos);
  wire markNow = modeReg[nr_pkg::MODE_MARK] && av1_reg && (hCount_reg == splitPos);
  wire [3:0] kYAuto = nr_pkg::adaptK(nr_pkg::kFromDepth(ctrl1[nr_pkg::YDEPTH_LSB +: 2]),
                                     motionNow, thr);
  wire [3:0] kCAuto = nr_pkg::adaptK(nr_pkg::kFromDepth(ctrl1[nr_pkg::CDEPTH_LSB +: 2]),
                                     motionNow, thr);
  wire [3:0] kYMan = nr_pkg::manualK(ctrlRegs_reg[nr_pkg::REG_MAN_Y]);
  wire [3:0] kCMan = nr_pkg::manualK(ctrlRegs_reg[nr_pkg::REG_MAN_C]);
  wire [3:0] kYNow = bypass ? nr_pkg::K_ONE : modeReg[nr_pkg::MODE_MAN_Y] ? kYMan : kYAuto;
  wire [3:0] kCNow = bypass ? nr_pkg::K_ONE : modeReg[nr_pkg::MODE_MAN_C] ? kCMan : kCAuto;

  // Stage 2: samples with their factors
  logic [YW-1:0] y2_reg;
  logic [YW-1:0] yd2_reg;
  logic [CW-1:0] cb2_reg;
  logic [CW-1:0] cbd2_reg;
  logic [CW-1:0] cr2_reg;
  logic [CW-1:0] crd2_reg;
  logic [3:0] kY2_reg;
  logic [3:0] kC2_reg;
  logic mark2_reg;
  logic [6:0] motion2_reg;

  always_ff @(posedge clk_sys or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      y2_reg <= '0;
      yd2_reg <= '0;
      cb2_reg <= '0;
      cbd2_reg <= '0;
      cr2_reg <= '0;
      crd2_reg <= '0;
      kY2_reg <= nr_pkg::K_ONE;
      kC2_reg <= nr_pkg::K_ONE;
      mark2_reg <= 1'b0;
      motion2_reg <= '0;
    end
    else if (pixEn)
    begin
      y2_reg <= y1_reg;
      yd2_reg <= yd1_reg;
      cb2_reg <= cb1_reg;
      cbd2_reg <= cbd1_reg;
      cr2_reg <= cr1_reg;
      crd2_reg <= crd1_reg;
      kY2_reg <= kYNow;
      kC2_reg <= kCNow;
      mark2_reg <= markNow;
      motion2_reg <= motionNow;
    end
  end

  // Stage 3: blend and saturate; the loop back to memory must never wrap
  wire [MW-1:0] yBlend = blend(MW'(y2_reg), MW'(yd2_reg), kY2_reg, YMAX);
  wire [MW-1:0] cbBlend = blend(MW'(cb2_reg), MW'(cbd2_reg), kC2_reg, CMAX);
  wire [MW-1:0] crBlend = blend(MW'(cr2_reg), MW'(crd2_reg), kC2_reg, CMAX);
  // The boundary marker is display only and also lands in memory, healing next frame
  wire [YW-1:0] yNext = mark2_reg ? {YW{1'b1}} : yBlend[YW-1:0];

  logic [YW-1:0] yOut_reg;
  logic [CW-1:0] cbOut_reg;
  logic [CW-1:0] crOut_reg;
  logic [7:0] readback_reg;

  // Readback ignores chip select and strobe
  wire [7:0] readSel = (addrSync < 3'(nr_pkg::NUM_RW_REGS)) ? ctrlRegs_reg[addrSync]
                     : (addrSync == nr_pkg::REG_STATUS) ? {1'b0, motion2_reg}
                     : 8'h00;

  always_ff @(posedge clk_sys or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      yOut_reg <= '0;
      cbOut_reg <= '0;
      crOut_reg <= '0;
      readback_reg <= '0;
    end
    else if (pixEn)
    begin
      yOut_reg <= yNext;
      cbOut_reg <= cbBlend[CW-1:0];
      crOut_reg <= crBlend[CW-1:0];
      readback_reg <= readSel;
    end
  end

  assign ctrl_readback = readback_reg;
  assign ctrlBusy = ctrlBusy_reg;
  assign luma_filtered_out = yOut_reg;
  assign blue_diff_filtered_out = cbOut_reg;
  assign red_diff_filtered_out = crOut_reg;
  assign lumaToDelayMem = yOut_reg;
  assign blue_diff_to_delay_mem = cbOut_reg;
  assign red_diff_to_delay_mem = crOut_reg;

  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (!sys_rst_n);

  sequence s_idle;
    !pixEn;
  endsequence
  sequence s_still;
    pixEn && (y2_reg == yd2_reg) && !mark2_reg;
  endsequence
  sequence s_ctrl1Write;
    commit && (wrPop.addr == nr_pkg::REG_CTRL1);
  endsequence

  property p_hold;
    s_idle |=> $stable(yOut_reg) && $stable(readback_reg) && $stable(kY2_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved without pixel enable");

  property p_write;
    s_ctrl1Write |=> (ctrl1 == $past(wrPop.data));
  endproperty
  a_write: assert property (p_write) else $error("control write not stored");

  property p_csGate;
    wrEvent |-> !$past(ctrl_select_n, 2) && $past(ctrl_write_strobe_n, 2)
      && !$past(ctrl_write_strobe_n, 3);
  endproperty
  a_csGate: assert property (p_csGate) else $error("write without select and strobe");

  property p_readback;
    pixEn && (addrSync == nr_pkg::REG_STATUS) |=> ctrl_readback == {1'b0, $past(motion2_reg)};
  endproperty
  a_readback: assert property (p_readback) else $error("status readback mismatch");

  property p_still;
    s_still |=> luma_filtered_out == $past(yd2_reg);
  endproperty
  a_still: assert property (p_still) else $error("static pixel altered");

  property p_clip;
    pixEn && (yAbs >= YW'(nr_pkg::MOTION_CLIP)) |=> motion2_reg == nr_pkg::MOTION_CLIP;
  endproperty
  a_clip: assert property (p_clip) else $error("motion not clipped at 127");

  property p_manual;
    pixEn && !bypass && modeReg[nr_pkg::MODE_MAN_Y] |=> kY2_reg == $past(kYMan);
  endproperty
  a_manual: assert property (p_manual) else $error("manual luma factor ignored");

  property p_adapt;
    pixEn && !bypass && !modeReg[nr_pkg::MODE_MAN_Y] && (motionNow >= thr)
      |=> kY2_reg == nr_pkg::K_ONE
          ##1 (!$past(pixEn) || $past(mark2_reg) || luma_filtered_out == $past(y2_reg));
  endproperty
  a_adapt: assert property (p_adapt) else $error("motion did not lift filtering");

  property p_mirror;
    (lumaToDelayMem == luma_filtered_out) && (red_diff_to_delay_mem == red_diff_filtered_out);
  endproperty
  a_mirror: assert property (p_mirror) else $error("memory write differs from output");
endmodule

// ### hw/nr_pkg.sv
// Shared constants, register layout and decode helpers for the noise reducer
package nr_pkg;
  // Register indices on the 3-bit control address
  localparam logic [2:0] REG_CTRL1 = 3'h0;
  localparam logic [2:0] REG_MODE = 3'h1;
  localparam logic [2:0] REG_MAN_Y = 3'h2;
  localparam logic [2:0] REG_MAN_C = 3'h3;
  localparam logic [2:0] REG_SPLIT_LO = 3'h4;
  localparam logic [2:0] REG_SPLIT_HI = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h6;
  localparam int NUM_RW_REGS = 6;
  // Reset values, register 0 in the low byte
  localparam logic [47:0] RST_VALS = 48'h0000_0000_0000;
  // Field positions
  localparam int SPEED_LSB = 4;
  localparam int CDEPTH_LSB = 2;
  localparam int YDEPTH_LSB = 0;
  localparam int MODE_MAN_Y = 0;
  localparam int MODE_MAN_C = 1;
  localparam int MODE_SPLIT = 6;
  localparam int MODE_MARK = 7;
  // Motion clip and k arithmetic (k in eighths, 8 means no filtering)
  localparam logic [6:0] MOTION_CLIP = 7'h7f;
  localparam logic [3:0] K_ONE = 4'h8;
  localparam int K_SHIFT = 3;
  localparam int K_ROUND = 4;
  localparam int SYNC_STAGES = 2;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data;
  } regWrite_s;

  function automatic logic [6:0] speedThr(input logic [2:0] s);
    case (s)
      3'h0: speedThr = 7'h18;
      3'h1: speedThr = 7'h20;
      3'h2: speedThr = 7'h28;
      3'h3: speedThr = 7'h30;
      3'h4: speedThr = 7'h38;
      3'h5: speedThr = 7'h3c;
      3'h6: speedThr = 7'h48;
      default: speedThr = 7'h50;
    endcase
  endfunction

  function automatic logic [3:0] kFromDepth(input logic [1:0] d);
    case (d)
      2'h0: kFromDepth = 4'h8;
      2'h1: kFromDepth = 4'h6;
      2'h2: kFromDepth = 4'h4;
      default: kFromDepth = 4'h2;
    endcase
  endfunction

  // Two-step ramp toward no filtering as motion approaches the threshold
  function automatic logic [3:0] adaptK(input logic [3:0] base, input logic [6:0] motion,
                                        input logic [6:0] thr);
    if (motion >= thr)
      adaptK = K_ONE;
    else if (motion >= (thr >> 1))
      // Fifth bit keeps a base of eight from wrapping to zero
      adaptK = 4'(({1'b0, base} + {1'b0, K_ONE}) >> 1);
    else
      adaptK = base;
  endfunction

  // Zero means filtering off; larger values filter harder, floor of one eighth
  function automatic logic [3:0] manualK(input logic [7:0] v);
    if (v > 8'h07)
      manualK = 4'h1;
    else
      manualK = 4'(K_ONE - {1'b0, v[2:0]});
  endfunction
endpackage

// ### hw/nr_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module nr_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  logic [AW:0] count;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  assign count = wrPtr_reg - rdPtr_reg;
  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr_reg[AW-1:0]];

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wrPtr_reg[AW-1:0]] <= inData;
  end

  always_ff @(posedge clk_sys or negedge sys_rst_n)
  begin
    if (!sys_rst_n)
    begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end
    else
    begin
      if (push)
        wrPtr_reg <= wrPtr_reg + 1'b1;
      if (pop)
        rdPtr_reg <= rdPtr_reg + 1'b1;
    end
  end
endmodule

// ### tb/frame_delay_model.sv
// Frame delay memory model: recirculates written pixels or returns preset samples
`timescale 1ns/10ps
module frame_delay_model #(
  parameter int YW = 10,
  parameter int CW = 10,
  parameter int DEPTH = 13
) (
  input wire logic clk_sys,
  input wire logic pixEn,
  input wire logic loopEn,
  input wire logic [YW-1:0] lumaWr,
  input wire logic [CW-1:0] blueWr,
  input wire logic [CW-1:0] redWr,
  input wire logic [YW-1:0] lumaPreset,
  input wire logic [CW-1:0] bluePreset,
  input wire logic [CW-1:0] redPreset,
  output logic [YW-1:0] lumaRd,
  output logic [CW-1:0] blueRd,
  output logic [CW-1:0] redRd
);
  // No reset, like real memory: the bench must fill it before closing the loop
  logic [YW+2*CW-1:0] store [DEPTH];
  always_ff @(posedge clk_sys)
  begin
    if (pixEn)
    begin
      store[0] <= {lumaWr, blueWr, redWr};
      for (int i = 1; i < DEPTH; i++)
        store[i] <= store[i-1];
    end
  end
  // Presets let a test place an exact delayed sample
  assign {lumaRd, blueRd, redRd} = loopEn ? store[DEPTH-1]
                                          : {lumaPreset, bluePreset, redPreset};
endmodule

// ### tb/noise_reducer_tb.sv
// Self-checking bench for the noise reducer top level
`timescale 1ns/10ps
module noise_reducer_tb;
  localparam int FRAME_LEN = 16;
  localparam int LATENCY = 3;
  logic clk_sys = 1'b0;
  logic sys_rst_n = 1'b0;
  logic pixEn = 1'b1;
  logic [2:0] ctrlAddr = 3'h0;
  logic [7:0] ctrlData = 8'h00;
  logic selN = 1'b1;
  logic strobeN = 1'b1;
  logic activeVideo = 1'b0;
  logic loopEn = 1'b0;
  logic [9:0] yIn = 10'h000, cbIn = 10'h200, crIn = 10'h200;
  logic [9:0] yPre = 10'h000, cbPre = 10'h200, crPre = 10'h200;
  logic [9:0] yDly, cbDly, crDly, yOut, cbOut, crOut, yMem, cbMem, crMem;
  logic [7:0] readback;
  logic busy;
  int miscompares = 0;
  int cmp_count = 0;

  always #4 clk_sys = ~clk_sys;

  noise_reducer noise_reducer_inst (.clk_sys(clk_sys), .sys_rst_n(sys_rst_n), .pixEn(pixEn),
    .ctrlAddr(ctrlAddr), .ctrlData(ctrlData), .ctrl_select_n(selN),
    .ctrl_write_strobe_n(strobeN), .activeVideo(activeVideo), .lumaLiveIn(yIn),
    .blue_diff_live_in(cbIn), .red_diff_live_in(crIn), .luma_delayed_in(yDly),
    .blue_diff_delayed_in(cbDly), .red_diff_delayed_in(crDly), .ctrl_readback(readback),
    .ctrlBusy(busy), .luma_filtered_out(yOut), .blue_diff_filtered_out(cbOut),
    .red_diff_filtered_out(crOut), .lumaToDelayMem(yMem), .blue_diff_to_delay_mem(cbMem),
    .red_diff_to_delay_mem(crMem));

  frame_delay_model #(.DEPTH(FRAME_LEN - LATENCY)) frame_delay_model_inst (.clk_sys(clk_sys),
    .pixEn(pixEn), .loopEn(loopEn), .lumaWr(yMem), .blueWr(cbMem), .redWr(crMem),
    .lumaPreset(yPre), .bluePreset(cbPre), .redPreset(crPre), .lumaRd(yDly), .blueRd(cbDly),
    .redRd(crDly));

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Strobe and select phases last at least the synchroniser's two-cycle minimum
  task automatic reg_write(input logic [2:0] a, input logic [7:0] d, input logic sel);
    @(negedge clk_sys);
    ctrlAddr = a;
    ctrlData = d;
    selN = ~sel;
    ticks(3);
    strobeN = 1'b0;
    ticks(2);
    strobeN = 1'b1;
    ticks(2);
    selN = 1'b1;
    ticks(6);
  endtask

  task automatic reg_read(input logic [2:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    ctrlAddr = a;
    ticks(5);
    chk({2'b00, readback}, {2'b00, e});
  endtask

  task automatic set_pix(input logic [9:0] y, cb, cr, yd, cbd, crd);
    @(negedge clk_sys);
    yIn = y;
    cbIn = cb;
    crIn = cr;
    yPre = yd;
    cbPre = cbd;
    crPre = crd;
    ticks(4);
  endtask

  task automatic check_out(input logic [9:0] ey, ecb, ecr);
    chk(yOut, ey);
    chk(cbOut, ecb);
    chk(crOut, ecr);
    chk(yMem, ey);
    chk(cbMem, ecb);
    chk(crMem, ecr);
  endtask

  task automatic test_reset_values;
    for (int a = 0; a < 8; a++)
      reg_read(3'(a), 8'h00);
    $display("reset values done");
  endtask

  task automatic test_regs;
    for (int a = 0; a < 6; a++)
      reg_write(3'(a), 8'ha0 + 8'(a), 1'b1);
    for (int a = 0; a < 6; a++)
      reg_read(3'(a), 8'ha0 + 8'(a));
    reg_write(3'h7, 8'hff, 1'b1);
    reg_read(3'h7, 8'h00);
    reg_write(3'h4, 8'h55, 1'b0);
    reg_read(3'h4, 8'ha4);
    chk({9'h000, busy}, 10'h000);
    for (int a = 0; a < 6; a++)
      reg_write(3'(a), 8'h00, 1'b1);
    $display("register access done");
  endtask

  task automatic test_manual;
    set_pix(10'h300, 10'h280, 10'h1c0, 10'h100, 10'h200, 10'h200);
    check_out(10'h300, 10'h280, 10'h1c0);
    reg_write(3'h1, 8'h03, 1'b1);
    reg_write(3'h2, 8'h04, 1'b1);
    reg_write(3'h3, 8'h06, 1'b1);
    set_pix(10'h300, 10'h280, 10'h200, 10'h100, 10'h200, 10'h200);
    check_out(10'h200, 10'h220, 10'h200);
    reg_write(3'h2, 8'h20, 1'b1);
    set_pix(10'h300, 10'h280, 10'h200, 10'h100, 10'h200, 10'h200);
    chk(yOut, 10'h140);
    for (int a = 1; a < 4; a++)
      reg_write(3'(a), 8'h00, 1'b1);
    $display("manual k done");
  endtask

  task automatic test_adaptive;
    logic [9:0] yLive [6] = '{10'h105, 10'h10c, 10'h110, 10'h118, 10'h300, 10'h0d0};
    logic [9:0] eY [6] = '{10'h101, 10'h108, 10'h10a, 10'h118, 10'h300, 10'h0d0};
    logic [9:0] eCb [6] = '{10'h210, 10'h228, 10'h228, 10'h240, 10'h240, 10'h240};
    logic [7:0] st [6] = '{8'h05, 8'h0c, 8'h10, 8'h18, 8'h7f, 8'h30};
    reg_write(3'h0, 8'h0f, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      set_pix(yLive[i], 10'h240, 10'h200, 10'h100, 10'h200, 10'h200);
      check_out(eY[i], eCb[i], 10'h200);
      reg_read(3'h6, st[i]);
    end
    reg_write(3'h0, 8'h00, 1'b1);
    // Half-threshold motion with filtering off must still pass the live pixel
    set_pix(10'h110, 10'h200, 10'h200, 10'h100, 10'h200, 10'h200);
    chk(yOut, 10'h110);
    $display("motion adaptation done");
  endtask

  task automatic test_split;
    reg_write(3'h4, 8'h02, 1'b1);
    reg_write(3'h2, 8'h04, 1'b1);
    reg_write(3'h1, 8'hc1, 1'b1);
    set_pix(10'h300, 10'h200, 10'h200, 10'h100, 10'h200, 10'h200);
    chk(yOut, 10'h200);
    activeVideo = 1'b1;
    ticks(3);
    chk(yOut, 10'h300);
    ticks(1);
    chk(yOut, 10'h300);
    ticks(1);
    chk(yOut, 10'h3ff);
    ticks(1);
    chk(yOut, 10'h200);
    activeVideo = 1'b0;
    for (int a = 1; a < 5; a++)
      reg_write(3'(a), 8'h00, 1'b1);
    $display("split screen done");
  endtask

  task automatic test_freeze;
    set_pix(10'h123, 10'h234, 10'h345, 10'h000, 10'h200, 10'h200);
    pixEn = 1'b0;
    yIn = 10'h2aa;
    ticks(5);
    chk(yOut, 10'h123);
    pixEn = 1'b1;
    ticks(2);
    chk(yOut, 10'h123);
    ticks(1);
    chk(yOut, 10'h2aa);
    $display("clock enable done");
  endtask

  task automatic test_reset_mid;
    reg_write(3'h0, 8'h0f, 1'b1);
    set_pix(10'h300, 10'h280, 10'h1c0, 10'h100, 10'h200, 10'h200);
    sys_rst_n = 1'b0;
    #1;
    check_out(10'h000, 10'h000, 10'h000);
    @(negedge clk_sys);
    sys_rst_n = 1'b1;
    ticks(3);
    reg_read(3'h0, 8'h00);
    $display("mid-run reset done");
  endtask

  task automatic test_loop;
    set_pix(10'h000, 10'h200, 10'h200, 10'h000, 10'h200, 10'h200);
    ticks(FRAME_LEN);
    reg_write(3'h1, 8'h01, 1'b1);
    reg_write(3'h2, 8'h04, 1'b1);
    @(negedge clk_sys);
    loopEn = 1'b1;
    yIn = 10'h200;
    ticks(4);
    chk(yOut, 10'h100);
    ticks(25 * FRAME_LEN);
    chk(yOut, 10'h200);
    chk(yDly, 10'h200);
    $display("recursive loop done");
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Tests need about 1100 cycles; allow ample margin before calling it a hang
  initial
  begin
    #200000;
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    ticks(4);
    sys_rst_n = 1'b1;
    ticks(3);
    test_reset_values();
    test_regs();
    test_manual();
    test_split();
    test_adaptive();
    test_freeze();
    test_reset_mid();
    test_loop();
    report_and_stop();
  end
endmodule
